//--- vtfg_pkg.sv
`default_nettype none

package vtfg_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int IDX_W = 13;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DET_FIELD1_VSYNC_LINES = 8'h4c;
	localparam logic [7:0] OFS_DET_FIELD1_VSYNC_CYCLES = 8'h50;
	localparam logic [7:0] OFS_GEN_VISIBLE_DIMENSIONS = 8'h60;
	localparam logic [7:0] OFS_GEN_EVENT_FLAGS = 8'h64;
	localparam logic [7:0] OFS_GEN_FORMAT_CONFIG = 8'h68;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_END_LSB = 16;
	localparam int POS_START_LSB = 0;
	localparam int POS_HEIGHT_LSB = 16;
	localparam int POS_WIDTH_LSB = 0;
	localparam int POS_PICTURE_START_FLAG = 2;
	localparam int POS_VERT_BLANK_START_FLAG = 1;
	localparam int POS_CHROMA_PARITY_LSB = 8;
	localparam int POS_FIELD_IDENT_LEVEL = 7;
	localparam int POS_SCAN_INTERLACED = 6;
	localparam int POS_FORMAT_LSB = 0;

	// ----------------------------------------------------------------
	// writable bits and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] WMASK_VISIBLE_DIMENSIONS = 32'h1fff_1fff;
	localparam logic [31:0] WMASK_FORMAT_CONFIG = 32'h0000_034f;
	localparam logic [31:0] RST_VISIBLE_DIMENSIONS = 32'h0000_0000;
	localparam logic [31:0] RST_FORMAT_CONFIG = 32'h0000_0000;

	// ----------------------------------------------------------------
	// format codes and generator frame totals
	// ----------------------------------------------------------------
	localparam logic [3:0] FMT_YUV420 = 4'h3;
	localparam logic [12:0] GEN_TOTAL_CYCLES = 13'h0100;
	localparam logic [12:0] GEN_TOTAL_LINES = 13'h0040;

	// ----------------------------------------------------------------
	// carriers and state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [31:0] wdata;
	} vtfg_reg_req_type;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} vtfg_reg_rsp_type;

	typedef struct packed {
		logic active_video;
		logic vert_blank;
		logic active_chroma;
		logic field_id;
	} vtfg_timing_type;

	typedef struct packed {
		logic armed;
		logic [12:0] value;
	} vtfg_capture_state_type;

	typedef struct packed {
		logic [2:0] vs_pipe;
		logic [2:0] hs_pipe;
		logic [2:0] fid_pipe;
		logic vs;
		logic hs;
		logic fid;
		logic [12:0] det_cycle;
		logic [12:0] det_line;
		logic [31:0] dims;
		logic [31:0] fmt;
		logic [1:0] flags;
		logic [12:0] gen_h;
		logic [12:0] gen_v;
		logic gen_field;
		vtfg_timing_type timing;
		vtfg_reg_rsp_type rsp;
	} vtfg_state_type;

endpackage : vtfg_pkg

`default_nettype wire

//--- vtfg_capture.sv
`default_nettype none

module vtfg_capture
(
	input wire logic clock,
	input wire logic rst_sync_b,
	input wire logic arm,
	input wire logic hit,
	input wire logic [12:0] index,
	output logic [12:0] captured
);
	import vtfg_pkg::*;

	vtfg_capture_state_type s;
	vtfg_capture_state_type next_s;

	// ----------------------------------------------------------------
	// keep only the first hit after each arm
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		if (hit && s.armed)
		begin
			next_s.value = index;
			next_s.armed = 1'b0;
		end
		else if (arm)
		begin
			next_s.armed = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign captured = s.value;

endmodule : vtfg_capture

`default_nettype wire

//--- vtfg_top.sv
// Overview of operation
// - report field-1 line where vsync input first deasserts, bits 28:16.
// - report field-1 line where vsync input first asserts, bits 12:0.
// - report field-1 cycle where vsync input first deasserts, bits 28:16.
// - report field-1 cycle where vsync input first asserts, bits 12:0.
// - visible height in lines comes from bits 28:16 of size register.
// - visible width in clock cycles comes from bits 12:0 of size register.
// - flag bit 2 set in first cycle active video output asserts.
// - flag bit 1 set in first cycle vertical blank output asserts.
// - chroma parity picks even or odd lines, every or even pixels.
// - bit 7 reads field identifier input level.
// - bit 6 selects progressive or interlaced generated timing.
// - formats 0, 1, 2 make chroma active exactly with active video.
// - format 3 makes chroma active only on every other active line.

`default_nettype none

module vtfg_top
(
	input wire logic clock,
	input wire logic rst_b,
	input wire vtfg_pkg::vtfg_reg_req_type reg_req,
	output var vtfg_pkg::vtfg_reg_rsp_type reg_rsp,
	input wire logic vsync_in,
	input wire logic hsync_in,
	input wire logic field_id_in,
	output var vtfg_pkg::vtfg_timing_type timing_out
);
	import vtfg_pkg::*;

	logic [1:0] rst_pipe;
	logic rst_sync_b;
	vtfg_state_type s;
	vtfg_state_type next_s;
	logic field1_arm;
	logic vs_rise;
	logic vs_fall;
	logic [12:0] start_line;
	logic [12:0] end_line;
	logic [12:0] start_cycle;
	logic [12:0] end_cycle;
	logic h_wrap;
	logic v_wrap;
	logic line_ok;
	logic pixel_ok;
	logic [31:0] clear_bits;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_pipe <= 2'h0;
		end
		else
		begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_pipe[1];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		field1_arm = 1'b0;
		vs_rise = 1'b0;
		vs_fall = 1'b0;
		h_wrap = 1'b0;
		v_wrap = 1'b0;
		line_ok = 1'b0;
		pixel_ok = 1'b0;
		clear_bits = 32'h0000_0000;

		// input synchronisers, change taken once stages two and three agree
		next_s.vs_pipe = {s.vs_pipe[1:0], vsync_in};
		next_s.hs_pipe = {s.hs_pipe[1:0], hsync_in};
		next_s.fid_pipe = {s.fid_pipe[1:0], field_id_in};
		if (s.vs_pipe[1] == s.vs_pipe[2])
		begin
			next_s.vs = s.vs_pipe[2];
		end
		if (s.hs_pipe[1] == s.hs_pipe[2])
		begin
			next_s.hs = s.hs_pipe[2];
		end
		if (s.fid_pipe[1] == s.fid_pipe[2])
		begin
			next_s.fid = s.fid_pipe[2];
		end

		// detector position counters
		if (next_s.hs && !s.hs)
		begin
			next_s.det_cycle = 13'h0000;
			next_s.det_line = s.det_line + 13'h0001;
		end
		else
		begin
			next_s.det_cycle = s.det_cycle + 13'h0001;
		end
		if (next_s.fid != s.fid)
		begin
			next_s.det_line = 13'h0000;
		end
		field1_arm = next_s.fid && !s.fid;
		vs_rise = s.fid && next_s.vs && !s.vs;
		vs_fall = s.fid && !next_s.vs && s.vs;

		// generator counters
		h_wrap = (s.gen_h >= GEN_TOTAL_CYCLES - 13'h0001);
		v_wrap = (s.gen_v >= GEN_TOTAL_LINES - 13'h0001);
		if (h_wrap)
		begin
			next_s.gen_h = 13'h0000;
			if (v_wrap)
			begin
				next_s.gen_v = 13'h0000;
				next_s.gen_field = s.fmt[POS_SCAN_INTERLACED] && !s.gen_field;
			end
			else
			begin
				next_s.gen_v = s.gen_v + 13'h0001;
			end
		end
		else
		begin
			next_s.gen_h = s.gen_h + 13'h0001;
		end

		// generated timing from visible size
		next_s.timing.active_video =
			(next_s.gen_h < s.dims[POS_WIDTH_LSB +: IDX_W]) &&
			(next_s.gen_v < s.dims[POS_HEIGHT_LSB +: IDX_W]);
		next_s.timing.vert_blank = (next_s.gen_v >= s.dims[POS_HEIGHT_LSB +: IDX_W]);
		next_s.timing.field_id = s.fmt[POS_SCAN_INTERLACED] && next_s.gen_field;

		// chroma activity
		line_ok = (next_s.gen_v[0] == s.fmt[POS_CHROMA_PARITY_LSB]);
		pixel_ok = !s.fmt[POS_CHROMA_PARITY_LSB + 1] || !next_s.gen_h[0];
		if (s.fmt[POS_FORMAT_LSB +: 4] == FMT_YUV420)
		begin
			next_s.timing.active_chroma = next_s.timing.active_video && line_ok && pixel_ok;
		end
		else
		begin
			next_s.timing.active_chroma = next_s.timing.active_video;
		end

		// register writes, reserved bits masked off
		if (reg_req.write)
		begin
			unique case (reg_req.addr)
				OFS_GEN_VISIBLE_DIMENSIONS:
				begin
					next_s.dims = reg_req.wdata & WMASK_VISIBLE_DIMENSIONS;
				end
				OFS_GEN_FORMAT_CONFIG:
				begin
					next_s.fmt = reg_req.wdata & WMASK_FORMAT_CONFIG;
				end
				OFS_GEN_EVENT_FLAGS:
				begin
					clear_bits = reg_req.wdata;
				end
				default:
				begin
					clear_bits = 32'h0000_0000;
				end
			endcase
		end

		// sticky flags, write one clears, new event wins
		next_s.flags[1] = (s.flags[1] && !clear_bits[POS_PICTURE_START_FLAG]) ||
			(next_s.timing.active_video && !s.timing.active_video);
		next_s.flags[0] = (s.flags[0] && !clear_bits[POS_VERT_BLANK_START_FLAG]) ||
			(next_s.timing.vert_blank && !s.timing.vert_blank);

		// register reads, unmapped and reserved bits read zero
		next_s.rsp.valid = reg_req.read;
		if (reg_req.read)
		begin
			unique case (reg_req.addr)
				OFS_DET_FIELD1_VSYNC_LINES:
				begin
					next_s.rsp.data = {3'h0, end_line, 3'h0, start_line};
				end
				OFS_DET_FIELD1_VSYNC_CYCLES:
				begin
					next_s.rsp.data = {3'h0, end_cycle, 3'h0, start_cycle};
				end
				OFS_GEN_VISIBLE_DIMENSIONS:
				begin
					next_s.rsp.data = s.dims;
				end
				OFS_GEN_EVENT_FLAGS:
				begin
					next_s.rsp.data = {29'h0000_0000, s.flags, 1'b0};
				end
				OFS_GEN_FORMAT_CONFIG:
				begin
					next_s.rsp.data = s.fmt;
					next_s.rsp.data[POS_FIELD_IDENT_LEVEL] = s.fid;
				end
				default:
				begin
					next_s.rsp.data = 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			s <= '0;
			s.dims <= RST_VISIBLE_DIMENSIONS;
			s.fmt <= RST_FORMAT_CONFIG;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// field-1 vertical sync position captures
	// ----------------------------------------------------------------
	vtfg_capture u_start_line
	(
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.arm(field1_arm),
		.hit(vs_rise),
		.index(next_s.det_line),
		.captured(start_line)
	);

	vtfg_capture u_end_line
	(
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.arm(field1_arm),
		.hit(vs_fall),
		.index(next_s.det_line),
		.captured(end_line)
	);

	vtfg_capture u_start_cycle
	(
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.arm(field1_arm),
		.hit(vs_rise),
		.index(next_s.det_cycle),
		.captured(start_cycle)
	);

	vtfg_capture u_end_cycle
	(
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.arm(field1_arm),
		.hit(vs_fall),
		.index(next_s.det_cycle),
		.captured(end_cycle)
	);

	assign reg_rsp = s.rsp;
	assign timing_out = s.timing;

endmodule : vtfg_top

`default_nettype wire

//--- vtfg_chk.sv
`default_nettype none

module vtfg_chk
(
	input wire logic clock,
	input wire logic rst_b,
	input wire vtfg_pkg::vtfg_reg_req_type reg_req,
	input wire vtfg_pkg::vtfg_reg_rsp_type reg_rsp,
	input wire vtfg_pkg::vtfg_timing_type timing_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import vtfg_pkg::*;

	// ----------------------------------------------------------------
	// shadow of writes and event history
	// ----------------------------------------------------------------
	logic pic;
	logic vbs;
	logic clr;
	logic [12:0] run;
	logic [12:0] lines;
	logic [15:0] age;
	logic [31:0] dims;
	logic [3:0] fmt;
	assign clr = reg_req.write && reg_req.addr == 8'h64;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pic <= 1'b0;
			vbs <= 1'b0;
			run <= '0;
			lines <= '0;
			age <= '0;
			dims <= '0;
			fmt <= '0;
		end
		else
		begin
			// a clear here wins, so only safe claims are made
			pic <= !(clr && reg_req.wdata[2]) && (pic || $rose(timing_out.active_video));
			vbs <= !(clr && reg_req.wdata[1]) && (vbs || $rose(timing_out.vert_blank));
			run <= timing_out.active_video ? run + 13'h1 : 13'h0;
			if ($rose(timing_out.vert_blank))
				lines <= '0;
			else if ($rose(timing_out.active_video))
				lines <= lines + 13'h1;
			if (reg_req.write && reg_req.addr == 8'h60)
			begin
				dims <= reg_req.wdata & WMASK_VISIBLE_DIMENSIONS;
				age <= '0;
			end
			else if (!age[15])
				age <= age + 16'h1;
			if (reg_req.write && reg_req.addr == 8'h68)
				fmt <= reg_req.wdata[3:0];
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_read_answer: assert property (reg_req.read |=> reg_rsp.valid)
		else $error("read got no answer");
	a_flag_resv: assert property (reg_rsp.valid && $past(reg_req.addr) == 8'h64
		|-> reg_rsp.data[31:3] == 29'h0 && !reg_rsp.data[0])
		else $error("flag reserved bits not zero");
	a_chroma_inside: assert property (timing_out.active_chroma |-> timing_out.active_video)
		else $error("chroma outside active video");
	a_chroma_equal: assert property (fmt < 4'h3 && $past(fmt, 2) == fmt
		|-> timing_out.active_chroma == timing_out.active_video)
		else $error("chroma differs from active video");
	a_pic_flag: assert property (reg_req.read && reg_req.addr == 8'h64 && pic
		|=> reg_rsp.data[2])
		else $error("picture start flag missing");
	a_vblank_flag: assert property (reg_req.read && reg_req.addr == 8'h64 && vbs
		|=> reg_rsp.data[1])
		else $error("vertical blank flag missing");
	a_width_run: assert property ($fell(timing_out.active_video) && age[9]
		|-> run == dims[12:0])
		else $error("active run differs from width");
	a_height_lines: assert property ($rose(timing_out.vert_blank) && age[15]
		|-> lines == dims[28:16])
		else $error("active lines differ from height");

	cover property ($rose(timing_out.active_chroma));
	cover property ($rose(timing_out.field_id));
	cover property (reg_rsp.valid);
endmodule : vtfg_chk

bind vtfg_top vtfg_chk u_chk (.clock, .rst_b, .reg_req, .reg_rsp, .timing_out);

`default_nettype wire

//--- vtfg_sync_src.sv
`default_nettype none

// free-running source: 64-cycle lines, 8-line fields
module vtfg_sync_src
(
	input wire logic clock,
	output logic vsync_in,
	output logic hsync_in,
	output logic field_id_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] t = 10'h000;

	always @(posedge clock)
	begin
		t <= #2 t + 10'h001;
	end

	assign hsync_in = t[5:0] < 6'h04;
	// vsync from line 2 cycle 5 to line 4 cycle 9
	assign vsync_in = t[8:0] >= 9'h085 && t[8:0] < 9'h109;
	assign field_id_in = (t[8:6] == 3'h0 && t[5:0] < 6'h0a) ? ~t[9] : t[9];
endmodule : vtfg_sync_src

`default_nettype wire

//--- tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import vtfg_pkg::*;
	logic clock;
	logic rst_b;
	vtfg_reg_req_type reg_req;
	vtfg_reg_rsp_type reg_rsp;
	vtfg_timing_type timing_out;
	logic vsync_in;
	logic hsync_in;
	logic field_id_in;
	logic vb_q;
	logic fid_prev;
	logic fid_last;
	logic [31:0] av_n;
	logic [31:0] ch_n;
	logic [31:0] last_av;
	logic [31:0] last_ch;
	logic [31:0] w;
	logic [31:0] h;
	logic [31:0] exp_q[$];
	int err_count;
	int n_compared;
	int nvb;

	vtfg_sync_src u_src (.clock, .vsync_in, .hsync_in, .field_id_in);
	vtfg_top u_dut (.clock, .rst_b, .reg_req, .reg_rsp, .vsync_in, .hsync_in, .field_id_in,
		.timing_out);

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task end_sim;
		$display("compared=%0d errors=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		#2 reg_req = '{1'b1, 1'b0, a, d};
		@(posedge clock);
		#2 reg_req.write = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		#2 reg_req = '{1'b0, 1'b1, a, 32'h0};
		exp_q.push_back(e);
		@(posedge clock);
		#2 reg_req.read = 1'b0;
	endtask : rd

	task frame(input int i);
		int n0;
		// written just after a vertical blank rise, so the next whole frame uses it
		wr(8'h68, 32'hfc00_0030 | 32'(i * 257) | (i == 3 ? 32'h40 : 32'h0));
		n0 = nvb;
		wait (nvb == n0 + 1);
		chk(last_av, w * h);
		chk(last_ch, i == 3 ? (h / 2) * (w / 2) : w * h);
		chk({31'h0, fid_last}, {31'h0, i == 3 ? ~fid_prev : 1'b0});
		$display("format test %0d done", i);
	endtask : frame

	// read answers and per-frame counts
	always @(negedge clock)
	begin
		if (reg_rsp.valid === 1'b1)
			chk(reg_rsp.data, exp_q.pop_front());
		if (timing_out.vert_blank === 1'b1 && vb_q === 1'b0)
		begin
			last_av = av_n;
			last_ch = ch_n;
			av_n = 0;
			ch_n = 0;
			fid_prev = fid_last;
			fid_last = timing_out.field_id;
			nvb++;
		end
		else
		begin
			av_n = av_n + {31'h0, timing_out.active_video};
			ch_n = ch_n + {31'h0, timing_out.active_chroma};
		end
		vb_q = timing_out.vert_blank;
	end

	initial
	begin
		#(95000 * 100);
		err_count++;
		end_sim;
	end

	initial
	begin
		reg_req = '0;
		rst_b = 1'b0;
		{vb_q, fid_prev, fid_last, av_n, ch_n, last_av, last_ch} = '0;
		{err_count, n_compared, nvb} = '0;
		void'($urandom(32'h1cc51010));
		repeat (5) @(posedge clock);
		#2 rst_b = 1'b1;
		repeat (3000) @(posedge clock);
		rd(8'h4c, 32'h0004_0002);
		wr(8'h4c, 32'hffff_ffff);
		rd(8'h4c, 32'h0004_0002);
		rd(8'h50, 32'h0009_0005);
		rd(8'h60, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h64, 32'h2);
		wr(8'h64, 32'hffff_ffff);
		rd(8'h64, 32'h0);
		$display("register test done");
		// even widths: one pixel per clock, every-other-pixel chroma count is w / 2
		w = $urandom_range(120, 2) & 32'hffff_fffe;
		h = $urandom_range(60, 4);
		wr(8'h60, 32'he000_e000 | (h << 16) | w);
		rd(8'h60, (h << 16) | w);
		wr(8'h68, 32'hfc00_03f3);
		wait (u_src.t[8:6] == 3'h3);
		rd(8'h68, 32'h0000_0343 | {24'h0, u_src.t[9], 7'h0});
		$display("setup test done");
		@(nvb);
		for (int i = 0; i < 4; i++)
			frame(i);
		rd(8'h64, 32'h6);
		repeat (2) @(posedge clock);
		end_sim;
	end
endmodule : tb_top

`default_nettype wire
